// >>> crcg_fifo.sv
// Purpose: byte fifo between the bus writes and the shift engine
// Assumes: single clock, synchronous reset
// Notes: depth is a power of two; count gives honest full and empty
`timescale 1ns/1ps
`default_nettype none
module crcg_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic full
);
  localparam int AW = $clog2(DEPTH); // pointer width
  logic [DEPTH-1:0][WIDTH-1:0] mem_r; // storage
  logic [AW-1:0] wptr_r; // write index
  logic [AW-1:0] rptr_r; // read index
  logic [AW:0] cnt_r; // occupancy
  logic push; // accepted write
  logic pop; // accepted read

  // handshakes from occupancy
  assign full = (cnt_r == (AW+1)'(DEPTH));
  assign in_ready = !full;
  assign out_valid = (cnt_r != '0);
  assign out_data = mem_r[rptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointers, count and storage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        mem_r[wptr_r] <= in_data;
        wptr_r <= wptr_r + 1'b1;
      end
      if (pop) begin
        rptr_r <= rptr_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // never pops an empty or pushes a full fifo
  a_fifo_bounds: assert property (@(posedge clk_sys) disable iff (srst)
    cnt_r <= (AW+1)'(DEPTH)) else $error("fifo count over depth");
endmodule
`default_nettype wire

// >>> crcg_pkg.sv
// Purpose: shared constants and types for the crc16 generator
// Assumes: avalon-mm slave with 32-bit data, one word per register
// Notes: offsets below are register indices; byte address is four times the index
package crcg_pkg;

  // register indices and bus widths
  localparam logic [1:0] CRCG_IDX_HIGH = 2'h0; // result_high_byte index
  localparam logic [1:0] CRCG_IDX_LOW = 2'h1; // result_low_byte index
  localparam logic [1:0] CRCG_IDX_MODE = 2'h2; // power mode control index
  localparam logic [1:0] CRCG_IDX_STAT = 2'h3; // status index
  localparam int CRCG_ADDR_W = 4; // byte address width
  localparam int CRCG_DATA_W = 32; // bus data width

  // generator constants
  localparam logic [15:0] CRCG_POLY = 16'h1021; // x^16+x^12+x^5+1
  localparam logic [15:0] CRCG_RESET_VAL = 16'h0000; // shift register reset value
  localparam int CRCG_FIFO_DEPTH = 16; // data byte fifo depth
  localparam int CRCG_FIFO_W = 8; // data byte width

  // mode register field layout
  localparam int CRCG_MODE_LSB = 0; // mode field lsb
  localparam logic [1:0] CRCG_MODE_RUN = 2'h0; // run or wait
  localparam logic [1:0] CRCG_MODE_STOP3 = 2'h1; // light standby, state held
  localparam logic [1:0] CRCG_MODE_STOP12 = 2'h2; // deep stop, state lost

  // status register field positions
  localparam int CRCG_ST_ARMED = 0; // seed high written, low pending
  localparam int CRCG_ST_BUSY = 1; // data bytes queued or shifting
  localparam int CRCG_ST_FULL = 2; // fifo full

  // engine states
  typedef enum logic [2:0] {
    CRCG_IDLE = 3'b001, // nothing to shift
    CRCG_SHIFT = 3'b010, // shifting one byte
    CRCG_HOLD = 3'b100 // frozen in light standby
  } crcg_state_t;

  // avalon request bundle
  typedef struct packed {
    logic [CRCG_ADDR_W-1:0] address;
    logic read;
    logic write;
    logic [CRCG_DATA_W-1:0] writedata;
  } crcg_req_t;

  // full state of the main module
  typedef struct packed {
    crcg_state_t st;
    logic [15:0] shreg;
    logic [7:0] byte_sh;
    logic [2:0] bit_cnt;
    logic armed;
    logic [1:0] mode;
    logic deep_seen;
    logic rvalid;
    logic [CRCG_DATA_W-1:0] rdata;
  } crcg_main_t;

  // full state of the fifo
  typedef struct packed {
    logic [CRCG_FIFO_DEPTH-1:0][CRCG_FIFO_W-1:0] mem;
    logic [3:0] wptr;
    logic [3:0] rptr;
    logic [4:0] count;
  } crcg_fifo_t;

endpackage

// >>> crcg_top.sv
// Purpose: crc16 generator with seed and data byte registers on avalon-mm
// Assumes: 20 MHz clk_sys, srst synchronous active high
// Notes: data bytes queue in a fifo; waitrequest stalls data writes when it is full
`timescale 1ns/1ps
`default_nettype none
module crcg_top (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  crcg_pkg::crcg_main_t s_r; // registered state
  crcg_pkg::crcg_main_t s_nxt; // next state
  crcg_pkg::crcg_req_t req; // bundled request
  logic [1:0] idx; // register index
  logic fifo_in_valid; // data byte push
  logic fifo_in_ready; // fifo can take a byte
  logic fifo_out_valid; // byte waiting
  logic fifo_out_ready; // engine takes byte
  logic [7:0] fifo_out_data; // byte to shift
  logic fifo_full; // fifo full flag
  logic data_wr; // low write treated as data
  logic engine_busy; // shifting or queued
  logic deep_rst; // fifo reset, driven by srst alone

  // one bit step of the generator
  function automatic logic [15:0] crcg_step(input logic [15:0] crc, input logic din);
    logic fb;
    fb = crc[15] ^ din;
    crcg_step = {crc[14:0], 1'b0} ^ (fb ? crcg_pkg::CRCG_POLY : 16'h0000);
  endfunction

  // read mux of the register file
  function automatic logic [31:0] crcg_rd(input logic [1:0] i, input crcg_pkg::crcg_main_t s,
                                          input logic busy, input logic full);
    case (i)
      crcg_pkg::CRCG_IDX_HIGH: crcg_rd = {24'h000000, s.shreg[15:8]};
      crcg_pkg::CRCG_IDX_LOW: crcg_rd = {24'h000000, s.shreg[7:0]};
      crcg_pkg::CRCG_IDX_MODE: crcg_rd = {30'h00000000, s.mode};
      crcg_pkg::CRCG_IDX_STAT: crcg_rd = {29'h00000000, full, busy, s.armed};
      default: crcg_rd = 32'h00000000;
    endcase
  endfunction

  // request bundle and index
  assign req = '{address: avs_address, read: avs_read, write: avs_write, writedata: avs_writedata};
  assign idx = req.address[3:2];
  assign engine_busy = fifo_out_valid || (s_r.st != crcg_pkg::CRCG_IDLE);
  assign deep_rst = srst;
  assign data_wr = req.write && avs_byteenable[0] && idx == crcg_pkg::CRCG_IDX_LOW && !s_r.armed
                   && !s_r.deep_seen && s_r.mode != crcg_pkg::CRCG_MODE_STOP12;
  assign fifo_in_valid = data_wr && !s_r.rvalid;
  // engine pulls a byte only when idle and running
  assign fifo_out_ready = s_r.st == crcg_pkg::CRCG_IDLE && s_r.mode == crcg_pkg::CRCG_MODE_RUN;

  // waitrequest: reads wait one cycle, data writes wait for fifo room,
  // seed writes in run mode wait until queued data has been shifted
  always_comb begin
    avs_waitrequest = 1'b0;
    if (req.read) begin
      avs_waitrequest = !s_r.rvalid;
    end else if (data_wr) begin
      avs_waitrequest = !fifo_in_ready;
    end else if (req.write && (idx == crcg_pkg::CRCG_IDX_HIGH || idx == crcg_pkg::CRCG_IDX_LOW)) begin
      avs_waitrequest = engine_busy && s_r.mode == crcg_pkg::CRCG_MODE_RUN;
    end
  end
  assign avs_readdata = s_r.rdata;

  crcg_fifo #(
    .WIDTH(crcg_pkg::CRCG_FIFO_W),
    .DEPTH(crcg_pkg::CRCG_FIFO_DEPTH)
  ) u_fifo (
    .clk_sys(clk_sys),
    .srst(deep_rst),
    .in_valid(fifo_in_valid && !avs_waitrequest),
    .in_ready(fifo_in_ready),
    .in_data(req.writedata[7:0]),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_out_ready),
    .out_data(fifo_out_data),
    .full(fifo_full)
  );

  // next state of the block
  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = 1'b0;
    // read data captured one cycle after request
    if (req.read && !s_r.rvalid) begin
      s_nxt.rdata = crcg_rd(idx, s_r, engine_busy, fifo_full);
      s_nxt.rvalid = 1'b1;
    end
    // mode register write
    if (req.write && !avs_waitrequest && idx == crcg_pkg::CRCG_IDX_MODE && avs_byteenable[0]) begin
      s_nxt.mode = req.writedata[crcg_pkg::CRCG_MODE_LSB +: 2];
      if (req.writedata[crcg_pkg::CRCG_MODE_LSB +: 2] == crcg_pkg::CRCG_MODE_STOP12) begin
        s_nxt.deep_seen = 1'b1;
      end
    end
    // leaving deep stop returns to reset state
    if (s_r.deep_seen && s_r.mode != crcg_pkg::CRCG_MODE_STOP12) begin
      s_nxt = '0;
      s_nxt.st = crcg_pkg::CRCG_IDLE;
      s_nxt.shreg = crcg_pkg::CRCG_RESET_VAL;
      s_nxt.mode = s_r.mode;
    end else if (s_r.mode != crcg_pkg::CRCG_MODE_STOP12) begin
      if (req.write && !avs_waitrequest && avs_byteenable[0]) begin
        if (idx == crcg_pkg::CRCG_IDX_HIGH) begin
          s_nxt.shreg[15:8] = req.writedata[7:0];
          s_nxt.armed = 1'b1;
        end else if (idx == crcg_pkg::CRCG_IDX_LOW && s_r.armed) begin
          // low seed byte into bits 7-0
          s_nxt.shreg[7:0] = req.writedata[7:0];
          s_nxt.armed = 1'b0;
        end
      end
      // shift engine
      case (s_r.st)
        crcg_pkg::CRCG_IDLE: begin
          if (fifo_out_valid && fifo_out_ready) begin
            s_nxt.byte_sh = fifo_out_data;
            s_nxt.bit_cnt = 3'h0;
            s_nxt.st = crcg_pkg::CRCG_SHIFT;
          end
        end
        crcg_pkg::CRCG_SHIFT: begin
          if (s_r.mode == crcg_pkg::CRCG_MODE_STOP3) begin
            s_nxt.st = crcg_pkg::CRCG_HOLD;
          end else begin
            // one bit per clock, msb first
            s_nxt.shreg = crcg_step(s_r.shreg, s_r.byte_sh[7]);
            s_nxt.byte_sh = {s_r.byte_sh[6:0], 1'b0};
            s_nxt.bit_cnt = s_r.bit_cnt + 3'h1;
            if (s_r.bit_cnt == 3'h7) begin
              s_nxt.st = crcg_pkg::CRCG_IDLE;
            end
          end
        end
        crcg_pkg::CRCG_HOLD: begin
          if (s_r.mode == crcg_pkg::CRCG_MODE_RUN) begin
            s_nxt.st = crcg_pkg::CRCG_SHIFT;
          end
        end
        default: s_nxt.st = crcg_pkg::CRCG_IDLE;
      endcase
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      s_r <= '0;
      s_r.st <= crcg_pkg::CRCG_IDLE;
      s_r.shreg <= crcg_pkg::CRCG_RESET_VAL;
    end else begin
      s_r <= s_nxt;
    end
  end

  // assertions
  a_step_poly: assert property (@(posedge clk_sys) disable iff (srst)
    (s_r.st == crcg_pkg::CRCG_SHIFT && s_r.mode == crcg_pkg::CRCG_MODE_RUN && !(s_r.deep_seen))
    |=> s_r.shreg == crcg_step($past(s_r.shreg), $past(s_r.byte_sh[7])))
    else $error("shift step wrong");
  a_seed_high: assert property (@(posedge clk_sys) disable iff (srst)
    (req.write && !avs_waitrequest && avs_byteenable[0] && idx == crcg_pkg::CRCG_IDX_HIGH
     && s_r.mode == crcg_pkg::CRCG_MODE_RUN && !s_r.deep_seen)
    |=> s_r.shreg[15:8] == $past(req.writedata[7:0]) && s_r.armed) else $error("seed high not loaded");
  a_seed_low: assert property (@(posedge clk_sys) disable iff (srst)
    (req.write && !avs_waitrequest && avs_byteenable[0] && idx == crcg_pkg::CRCG_IDX_LOW && s_r.armed
     && s_r.mode == crcg_pkg::CRCG_MODE_RUN && !s_r.deep_seen)
    |=> s_r.shreg[7:0] == $past(req.writedata[7:0]) && !s_r.armed) else $error("seed low not loaded");
  a_read_live: assert property (@(posedge clk_sys) disable iff (srst)
    (req.read && !s_r.rvalid && idx == crcg_pkg::CRCG_IDX_LOW)
    |=> s_r.rvalid && avs_readdata[7:0] == $past(s_r.shreg[7:0])) else $error("read not live");
  // a standby entered mid byte stretches the byte, so that attempt is dropped
  a_byte_time: assert property (@(posedge clk_sys)
    disable iff (srst || s_r.mode != crcg_pkg::CRCG_MODE_RUN)
    (s_r.st == crcg_pkg::CRCG_IDLE && fifo_out_valid && fifo_out_ready && !s_r.deep_seen)
    |=> (s_r.st == crcg_pkg::CRCG_SHIFT)[*8] ##1 s_r.st == crcg_pkg::CRCG_IDLE)
    else $error("byte not shifted in 8");
  a_stop3_hold: assert property (@(posedge clk_sys) disable iff (srst)
    (s_r.st == crcg_pkg::CRCG_HOLD && s_r.mode == crcg_pkg::CRCG_MODE_STOP3)
    |=> $stable(s_r.shreg)) else $error("shreg moved in standby");
  a_deep_reset: assert property (@(posedge clk_sys) disable iff (srst)
    (s_r.deep_seen && s_r.mode != crcg_pkg::CRCG_MODE_STOP12)
    |=> s_r.shreg == crcg_pkg::CRCG_RESET_VAL && !s_r.armed) else $error("no reset after deep stop");
  a_no_invert: assert property (@(posedge clk_sys) disable iff (srst)
    (s_r.st == crcg_pkg::CRCG_SHIFT && s_r.mode == crcg_pkg::CRCG_MODE_RUN && s_r.shreg == 16'h0000
     && !s_r.byte_sh[7] && !s_r.deep_seen) |=> s_r.shreg == 16'h0000) else $error("result inverted");
  a_split_high: assert property (@(posedge clk_sys) disable iff (srst)
    (req.read && !s_r.rvalid && idx == crcg_pkg::CRCG_IDX_HIGH)
    |=> avs_readdata == {24'h000000, $past(s_r.shreg[15:8])}) else $error("high byte wrong");
  a_wait_runs: assert property (@(posedge clk_sys) disable iff (srst)
    (s_r.st == crcg_pkg::CRCG_HOLD && s_r.mode == crcg_pkg::CRCG_MODE_RUN && !s_r.deep_seen)
    |=> s_r.st == crcg_pkg::CRCG_SHIFT) else $error("no resume");

  c_seed: cover property (@(posedge clk_sys) s_r.armed ##[1:20] !s_r.armed);
  c_byte: cover property (@(posedge clk_sys) s_r.st == crcg_pkg::CRCG_SHIFT ##8 s_r.st == crcg_pkg::CRCG_IDLE);
  c_full: cover property (@(posedge clk_sys) fifo_full && avs_waitrequest);
  c_hold: cover property (@(posedge clk_sys) s_r.st == crcg_pkg::CRCG_HOLD);
endmodule
`default_nettype wire

// >>> crcg_top_tb.sv
// Purpose: self-checking bench for the crc16 generator on avalon-mm
// Assumes: 50 ns clk_sys, srst held high for 20 cycles, bench drives the bus itself
// Notes: expected results come from known vectors and a bench-side bit model
`timescale 1ns/1ps
`default_nettype none
module crcg_top_tb;
  logic clk_sys; // bus clock
  logic srst; // synchronous reset
  logic [3:0] avs_address; // byte address
  logic avs_read; // read request
  logic avs_write; // write request
  logic [31:0] avs_writedata; // write data
  logic [3:0] avs_byteenable; // byte lanes
  logic [31:0] avs_readdata; // read data from uut
  logic avs_waitrequest; // stall from uut
  int n_fail; // mismatches
  int n_checks; // comparisons made
  logic [31:0] rd_v; // last value read
  logic [15:0] exp_v; // model result
  // byte addresses of the four words
  localparam logic [3:0] A_HI = {crcg_pkg::CRCG_IDX_HIGH, 2'h0};
  localparam logic [3:0] A_LO = {crcg_pkg::CRCG_IDX_LOW, 2'h0};
  localparam logic [3:0] A_MD = {crcg_pkg::CRCG_IDX_MODE, 2'h0};
  localparam logic [3:0] A_ST = {crcg_pkg::CRCG_IDX_STAT, 2'h0};
  // known vectors: seed, message length, result
  logic [15:0] v_seed [5] = '{16'h0000, 16'hffff, 16'h1d0f, 16'h0000, 16'hffff};
  int v_len [5] = '{1, 1, 1, 9, 9};
  logic [15:0] v_res [5] = '{16'h58e5, 16'hb915, 16'h9479, 16'h31c3, 16'h29b1};

  crcg_top uut (
    .clk_sys(clk_sys),
    .srst(srst),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest)
  );

  // free-running clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // verdict and end of run
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one comparison
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // avalon write, held until waitrequest low
  task automatic bus_wr(input logic [3:0] a, input logic [7:0] d, input logic be0);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= {3'h0, be0};
    avs_write <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 400);
    avs_write <= 1'b0;
    if (n >= 400) chk(32'h1, 32'h0, "write stalled");
  endtask

  // avalon read, data taken at the releasing edge
  task automatic bus_rd(input logic [3:0] a, output logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_read <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 400);
    v = avs_readdata;
    avs_read <= 1'b0;
    if (n >= 400) chk(32'h1, 32'h0, "read stalled");
  endtask

  // bench model: one byte, msb first, unaugmented, not inverted
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic fb;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ b[i];
      c = {c[14:0], 1'b0};
      if (fb) c = c ^ crcg_pkg::CRCG_POLY;
    end
    return c;
  endfunction

  // seed high then low
  task automatic seed(input logic [15:0] s);
    bus_wr(A_HI, s[15:8], 1'b1);
    bus_wr(A_LO, s[7:0], 1'b1);
  endtask

  // poll busy flag, bounded
  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      bus_rd(A_ST, rd_v);
      k++;
    end while (rd_v[crcg_pkg::CRCG_ST_BUSY] !== 1'b0 && k < 200);
    chk({31'h0, rd_v[crcg_pkg::CRCG_ST_BUSY]}, 32'h0, "busy never cleared");
  endtask

  // read both result bytes, unused bits zero
  task automatic chk_res(input logic [15:0] e, input string what);
    bus_rd(A_HI, rd_v);
    chk(rd_v, {24'h0, e[15:8]}, what);
    bus_rd(A_LO, rd_v);
    chk(rd_v, {24'h0, e[7:0]}, what);
  endtask

  // watchdog, far above the expected run length
  initial begin
    repeat (40000) @(posedge clk_sys);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done();
  end

  // main sequence
  initial begin
    n_fail = 0;
    n_checks = 0;
    srst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    // reset state
    chk_res(16'h0000, "reset result");
    bus_rd(A_ST, rd_v);
    chk(rd_v, 32'h0, "reset status");
    $display("test reset done");
    // seed halves, arming, reload, ignored lane
    bus_wr(A_HI, 8'h12, 1'b1);
    bus_rd(A_HI, rd_v);
    chk(rd_v, 32'h12, "seed high");
    bus_rd(A_ST, rd_v);
    chk(rd_v, 32'h1, "armed after high");
    bus_wr(A_HI, 8'hab, 1'b1);
    bus_wr(A_LO, 8'h34, 1'b1);
    chk_res(16'hab34, "seed reload");
    bus_rd(A_ST, rd_v);
    chk(rd_v, 32'h0, "disarmed after low");
    bus_wr(A_LO, 8'hff, 1'b0);
    chk_res(16'hab34, "lane off write");
    $display("test seed done");
    // known vectors in run mode
    for (int t = 0; t < 5; t++) begin
      seed(v_seed[t]);
      for (int i = 0; i < v_len[t]; i++) begin
        bus_wr(A_LO, (v_len[t] == 1) ? 8'h41 : 8'h31 + 8'(i), 1'b1);
      end
      wait_idle();
      chk_res(v_res[t], "vector result");
    end
    $display("test vectors done");
    // light standby freezes then resumes
    seed(16'hffff);
    bus_wr(A_MD, {6'h0, crcg_pkg::CRCG_MODE_STOP3}, 1'b1);
    bus_wr(A_LO, 8'h41, 1'b1);
    repeat (20) @(posedge clk_sys);
    chk_res(16'hffff, "frozen result");
    bus_wr(A_MD, {6'h0, crcg_pkg::CRCG_MODE_RUN}, 1'b1);
    wait_idle();
    chk_res(16'hb915, "resumed result");
    $display("test standby done");
    // deep stop loses state
    seed(16'h1234);
    bus_wr(A_HI, 8'h55, 1'b1);
    bus_wr(A_MD, {6'h0, crcg_pkg::CRCG_MODE_STOP12}, 1'b1);
    bus_wr(A_MD, {6'h0, crcg_pkg::CRCG_MODE_RUN}, 1'b1);
    chk_res(crcg_pkg::CRCG_RESET_VAL, "deep stop recovery");
    bus_rd(A_ST, rd_v);
    chk(rd_v, 32'h0, "deep stop status");
    $display("test deep stop done");
    // fill the queue while frozen, then drain
    seed(16'h0000);
    exp_v = 16'h0000;
    bus_wr(A_MD, {6'h0, crcg_pkg::CRCG_MODE_STOP3}, 1'b1);
    for (int i = 0; i < crcg_pkg::CRCG_FIFO_DEPTH; i++) begin
      bus_wr(A_LO, 8'(i * 17 + 3), 1'b1);
      exp_v = crc_step(exp_v, 8'(i * 17 + 3));
    end
    bus_rd(A_ST, rd_v);
    chk({31'h0, rd_v[crcg_pkg::CRCG_ST_FULL]}, 32'h1, "queue full");
    bus_wr(A_MD, {6'h0, crcg_pkg::CRCG_MODE_RUN}, 1'b1);
    wait_idle();
    chk_res(exp_v, "drained result");
    bus_rd(A_ST, rd_v);
    chk(rd_v, 32'h0, "queue empty");
    $display("test queue done");
    test_done();
  end
endmodule
`default_nettype wire
